// [mcd_consts.vh]
// command codes, status layout and setup constants for the measure decoder
// Operation
// - AD runs four cycles, stores mean
// - AE runs eight cycles, stores mean
// - AF runs sixteen cycles, stores mean
// - B0 selects primary setup, clears status bit1
// - B1 selects alternate setup, sets status bit1
// - BF halts periodic operation, enters sleep
// - Fx returns status and last result
// - every result is a 24-bit word
// - A0 uses selected stored setup word
// - odd raw codes use host setup word
// - A2/A3 auto-zero corrected sensor capture
// - A4/A6 temperature capture, fixed internal setup
// - host temp setup ignores bits 15..12
// - cycle: sensor zero, sensor, temp zero, temp
// - response is status then data word
// - busy until result ready, commands refused
// - raw capture stores unconditioned result
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH
`define MCD_CMD_MEASURE   8'haa
`define MCD_CMD_OVS2      8'hac
`define MCD_CMD_OVS4      8'had
`define MCD_CMD_OVS8      8'hae
`define MCD_CMD_OVS16     8'haf
`define MCD_CMD_SEL_PRI   8'hb0
`define MCD_CMD_SEL_ALT   8'hb1
`define MCD_CMD_HALT      8'hbf
`define MCD_CMD_RAW_HI    5'h14
`define MCD_CMD_NOP_HI    4'hf
`define MCD_ADDR_PRI      6'h12
`define MCD_ADDR_ALT      6'h16
`define MCD_ST_POWER      6
`define MCD_ST_BUSY       5
`define MCD_ST_CFG        1
`define MCD_CFG_RESET     1'b0
`define MCD_TEMP_MASK     16'h0fff
`define MCD_PH_SZERO      2'h0
`define MCD_PH_SCONV      2'h1
`define MCD_PH_TZERO      2'h2
`define MCD_PH_TCONV      2'h3
`endif

// [mcd_avg.v]
// accumulator that forms truncated means of sensor and temperature words
`timescale 1ns/1ps
module mcd_avg #(
    parameter W    = 24,
    parameter SUMW = 28
) (
    // clock and reset
    input  wire            sys_clk,
    input  wire            reset_n,
    // control
    input  wire            clear,
    input  wire            addEn,
    input  wire [2:0]      shift,
    // samples
    input  wire [W-1:0]    sensorIn,
    input  wire [W-1:0]    tempIn,
    // means
    output wire [W-1:0]    meanSensor,
    output wire [W-1:0]    meanTemp
);
    reg  [SUMW-1:0] sumSensor;
    reg  [SUMW-1:0] sumTemp;
    wire [SUMW-1:0] shSensor;
    wire [SUMW-1:0] shTemp;

    always @(posedge sys_clk) begin
        if (!reset_n || clear) begin
            sumSensor <= {SUMW{1'b0}};
            sumTemp   <= {SUMW{1'b0}};
        end else if (addEn) begin
            sumSensor <= sumSensor + {{(SUMW-W){1'b0}}, sensorIn};
            sumTemp   <= sumTemp + {{(SUMW-W){1'b0}}, tempIn};
        end
    end

    assign shSensor   = sumSensor >> shift;
    assign shTemp     = sumTemp >> shift;
    assign meanSensor = shSensor[W-1:0];
    assign meanTemp   = shTemp[W-1:0];
endmodule

// [mcd_decoder.v]
// command interpreter for measurement, setup select, halt and raw capture
`timescale 1ns/1ps
`include "mcd_consts.vh"
module mcd_decoder #(
    parameter W          = 24,
    parameter TEMP_SETUP = 16'h0000
) (
    // clock and reset
    input  wire          sys_clk,
    input  wire          reset_n,
    // command from the serial front end
    input  wire          cmdValid,
    input  wire [7:0]    cmdByte,
    input  wire [15:0]   cmdData,
    output wire          cmdReady,
    // stored setup words
    input  wire [15:0]   sensorSetupPrimary,
    input  wire [15:0]   sensorSetupAlternate,
    // other status sources
    input  wire [1:0]    modeStatus,
    input  wire          memError,
    // analog front end
    output reg           afeStart,
    output reg  [1:0]    afePhase,
    output reg  [15:0]   afeSetup,
    input  wire          afeDone,
    input  wire [W-1:0]  afeResult,
    // correction math
    output reg           calcStart,
    input  wire          calcDone,
    input  wire [W-1:0]  calcSensor,
    input  wire [W-1:0]  calcTemp,
    input  wire          calcSat,
    // power and cyclic control
    output reg           haltPeriodic,
    output reg           sleepMode,
    // response
    output wire [7:0]    statusByte,
    output reg  [W-1:0]  outSensor,
    output reg  [W-1:0]  outTemp,
    output reg           respValid,
    output reg           dataValid
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_PHASE = 2'h1;
    localparam ST_WAIT  = 2'h2;
    localparam ST_CALC  = 2'h3;

    reg  [1:0]   state;
    reg          cfgAlt;
    reg          aluSat;
    reg          isRaw;
    reg          rawZero;
    reg  [1:0]   lastPhase;
    reg  [15:0]  hostSetup;
    reg          useHost;
    reg  [4:0]   runsLeft;
    reg  [2:0]   avgShift;
    reg  [W-1:0] zeroVal;
    reg          avgClear;
    reg          avgAdd;
    wire [W-1:0] meanSensor;
    wire [W-1:0] meanTemp;
    wire         take;
    wire         isNop;
    wire         isRawCmd;
    reg  [4:0]   ovsRuns;
    reg  [2:0]   ovsShift;
    wire [15:0]  selSetup;
    wire [15:0]  tempSetup;
    wire         addNow;

    assign cmdReady = (state == ST_IDLE);
    assign take     = cmdValid && cmdReady;
    assign isNop    = (cmdByte[7:4] == `MCD_CMD_NOP_HI);
    assign isRawCmd = (cmdByte[7:3] == `MCD_CMD_RAW_HI);

    assign statusByte = {1'b0, 1'b1, ~cmdReady, modeStatus, memError,
                         cfgAlt, aluSat};

    assign selSetup  = cfgAlt ? sensorSetupAlternate : sensorSetupPrimary;
    assign tempSetup = useHost ? (hostSetup & `MCD_TEMP_MASK) : TEMP_SETUP;
    // correction words only hold with the done pulse, so add right then
    assign addNow    = (state == ST_CALC) && calcDone;

    always @* begin
        case (cmdByte)
            `MCD_CMD_OVS2: begin
                ovsRuns  = 5'h02;
                ovsShift = 3'h1;
            end
            `MCD_CMD_OVS4: begin
                ovsRuns  = 5'h04;
                ovsShift = 3'h2;
            end
            `MCD_CMD_OVS8: begin
                ovsRuns  = 5'h08;
                ovsShift = 3'h3;
            end
            `MCD_CMD_OVS16: begin
                ovsRuns  = 5'h10;
                ovsShift = 3'h4;
            end
            default: begin
                ovsRuns  = 5'h01;
                ovsShift = 3'h0;
            end
        endcase
    end

    mcd_avg #(
        .W    (W),
        .SUMW (W + 4)
    ) u_avg (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .clear      (avgClear),
        .addEn      (addNow),
        .shift      (avgShift),
        .sensorIn   (calcSensor),
        .tempIn     (calcTemp),
        .meanSensor (meanSensor),
        .meanTemp   (meanTemp)
    );

    always @(posedge sys_clk) begin
        if (!reset_n) begin
            state        <= ST_IDLE;
            cfgAlt       <= `MCD_CFG_RESET;
            aluSat       <= 1'b0;
            isRaw        <= 1'b0;
            rawZero      <= 1'b0;
            lastPhase    <= `MCD_PH_SZERO;
            hostSetup    <= 16'h0000;
            useHost      <= 1'b0;
            runsLeft     <= 5'h00;
            avgShift     <= 3'h0;
            zeroVal      <= {W{1'b0}};
            avgClear     <= 1'b0;
            avgAdd       <= 1'b0;
            afeStart     <= 1'b0;
            afePhase     <= `MCD_PH_SZERO;
            afeSetup     <= 16'h0000;
            calcStart    <= 1'b0;
            haltPeriodic <= 1'b0;
            sleepMode    <= 1'b0;
            outSensor    <= {W{1'b0}};
            outTemp      <= {W{1'b0}};
            respValid    <= 1'b0;
            dataValid    <= 1'b0;
        end else begin
            afeStart     <= 1'b0;
            calcStart    <= 1'b0;
            haltPeriodic <= 1'b0;
            respValid    <= 1'b0;
            avgClear     <= 1'b0;
            avgAdd       <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        if (isNop) begin
                            respValid <= 1'b1;
                        end else begin
                            // other commands invalidate old data
                            dataValid <= 1'b0;
                            aluSat    <= 1'b0;
                            if (cmdByte == `MCD_CMD_SEL_PRI) begin
                                cfgAlt <= 1'b0;
                            end else if (cmdByte == `MCD_CMD_SEL_ALT) begin
                                cfgAlt <= 1'b1;
                            end else if (cmdByte == `MCD_CMD_HALT) begin
                                haltPeriodic <= 1'b1;
                                sleepMode    <= 1'b1;
                            end else if (isRawCmd) begin
                                useHost   <= cmdByte[0];
                                hostSetup <= cmdByte[0] ? cmdData : selSetup;
                                isRaw     <= 1'b1;
                                rawZero   <= cmdByte[1];
                                afePhase  <= {cmdByte[2], ~cmdByte[1]};
                                lastPhase <= {cmdByte[2], 1'b1};
                                runsLeft  <= 5'h01;
                                sleepMode <= 1'b0;
                                state     <= ST_PHASE;
                            end else if (cmdByte == `MCD_CMD_MEASURE ||
                                         cmdByte[7:2] == 6'h2b) begin
                                // AA and AC..AF: full averaged cycles
                                useHost   <= 1'b0;
                                hostSetup <= selSetup;
                                isRaw     <= 1'b0;
                                afePhase  <= `MCD_PH_SZERO;
                                lastPhase <= `MCD_PH_TCONV;
                                runsLeft  <= ovsRuns;
                                avgShift  <= ovsShift;
                                avgClear  <= 1'b1;
                                sleepMode <= 1'b0;
                                state     <= ST_PHASE;
                            end
                        end
                    end
                end
                ST_PHASE: begin
                    afeStart <= 1'b1;
                    afeSetup <= afePhase[1] ? tempSetup : hostSetup;
                    state    <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (afeDone) begin
                        if (afePhase != lastPhase) begin
                            zeroVal  <= afeResult;
                            afePhase <= afePhase + 2'h1;
                            state    <= ST_PHASE;
                        end else if (isRaw) begin
                            outSensor <= rawZero ? afeResult - zeroVal
                                                 : afeResult;
                            outTemp   <= {W{1'b0}};
                            dataValid <= 1'b1;
                            respValid <= 1'b1;
                            state     <= ST_IDLE;
                        end else begin
                            calcStart <= 1'b1;
                            state     <= ST_CALC;
                        end
                    end
                end
                default: begin
                    if (calcDone) begin
                        avgAdd <= 1'b1;
                        aluSat <= aluSat | calcSat;
                        runsLeft <= runsLeft - 5'h01;
                        if (runsLeft != 5'h01) begin
                            afePhase <= `MCD_PH_SZERO;
                            state    <= ST_PHASE;
                        end else begin
                            // the last add already landed with this done pulse; output still waits one cycle for avgAdd to clear
                            runsLeft <= 5'h00;
                        end
                    end else if (runsLeft == 5'h00 && !avgAdd) begin
                        outSensor <= meanSensor;
                        outTemp   <= meanTemp;
                        dataValid <= 1'b1;
                        respValid <= 1'b1;
                        state     <= ST_IDLE;
                    end
                end
            endcase
        end
    end
endmodule

// [mcd_decoder_props.sv]
// port assertions for the measure command decoder
`timescale 1ns/1ps
module mcd_checker #(
    parameter W = 24
) (
    // clock and reset
    input wire logic          sys_clk,
    input wire logic          reset_n,
    // command side
    input wire logic          cmdValid,
    input wire logic [7:0]    cmdByte,
    input wire logic [15:0]   cmdData,
    input wire logic          cmdReady,
    input wire logic [15:0]   sensorSetupPrimary,
    input wire logic [1:0]    modeStatus,
    input wire logic          memError,
    // front end and control
    input wire logic          afeStart,
    input wire logic [1:0]    afePhase,
    input wire logic [15:0]   afeSetup,
    input wire logic          haltPeriodic,
    input wire logic          sleepMode,
    // response
    input wire logic [7:0]    statusByte,
    input wire logic [W-1:0]  outSensor,
    input wire logic          respValid
);
    wire cmdTaken;
    assign cmdTaken = cmdValid && cmdReady;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    a_status_layout: assert property (statusByte[7:6] == 2'b01 &&
        statusByte[4:2] == {modeStatus, memError}) else $error("status");
    a_busy_flag: assert property (statusByte[5] == !cmdReady)
        else $error("busy flag");
    a_refuse_hold: assert property (!cmdReady |=> $stable(statusByte[1]))
        else $error("busy command ran");
    a_pick_primary: assert property (cmdTaken && cmdByte == 8'hb0
        |=> !statusByte[1]) else $error("primary select");
    a_pick_alternate: assert property (cmdTaken && cmdByte == 8'hb1
        |=> statusByte[1]) else $error("alternate select");
    a_halt_sleep: assert property (cmdTaken && cmdByte == 8'hbf
        |=> haltPeriodic && sleepMode) else $error("halt");
    a_nop_reply: assert property (cmdTaken && cmdByte[7:4] == 4'hf
        |=> respValid && $stable(outSensor)) else $error("nop reply");
    a_raw_start: assert property (cmdTaken && cmdByte[7:3] == 5'h14
        |=> !cmdReady ##1 afeStart) else $error("raw start");
    a_stored_setup: assert property (cmdTaken && cmdByte == 8'ha0 &&
        !statusByte[1] |-> ##2 afeSetup == sensorSetupPrimary)
        else $error("stored setup");
    a_temp_mask: assert property (cmdTaken && cmdByte == 8'ha5
        |-> ##2 afeSetup == ($past(cmdData, 2) & 16'h0fff))
        else $error("temp mask");
    a_measure_order: assert property (cmdTaken && cmdByte == 8'had
        |-> ##2 afeStart && afePhase == 2'h0) else $error("phase order");
endmodule
bind mcd_decoder mcd_checker #(.W(W)) chk (
    .sys_clk(sys_clk), .reset_n(reset_n), .cmdValid(cmdValid),
    .cmdByte(cmdByte), .cmdData(cmdData), .cmdReady(cmdReady),
    .sensorSetupPrimary(sensorSetupPrimary), .modeStatus(modeStatus),
    .memError(memError), .afeStart(afeStart), .afePhase(afePhase),
    .afeSetup(afeSetup), .haltPeriodic(haltPeriodic),
    .sleepMode(sleepMode), .statusByte(statusByte),
    .outSensor(outSensor), .respValid(respValid));

// [mcd_afe_model.sv]
// front end and correction engine stand-in facing the decoder
`timescale 1ns/1ps
module mcd_afe_model (
    // clock, reset and pacing
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire [3:0]  lag,
    input  wire        idle,
    // conversion side
    input  wire        afeStart,
    input  wire [1:0]  afePhase,
    input  wire [15:0] afeSetup,
    output reg         afeDone,
    output reg  [23:0] afeResult,
    // correction side
    input  wire        calcStart,
    output reg         calcDone,
    output reg  [23:0] calcSensor,
    output reg  [23:0] calcTemp,
    output wire        calcSat,
    // bookkeeping
    output reg  [15:0] lastSetup,
    output reg  [15:0] afeCount,
    output reg  [15:0] calcCount
);
    reg [3:0] aWait;
    reg [3:0] cWait;
    reg [1:0] aPh;
    reg [7:0] run;
    // saturation on the third run only, so the flag must be or-ed
    assign calcSat = (run == 8'h03);
    always @(posedge sys_clk) begin
        afeDone <= 1'b0;
        calcDone <= 1'b0;
        // data lines toggle when not valid, never hold stale values
        afeResult <= ~afeResult;
        calcSensor <= ~calcSensor;
        calcTemp <= ~calcTemp;
        if (aWait != 4'h0) aWait <= aWait - 4'h1;
        if (cWait != 4'h0) cWait <= cWait - 4'h1;
        if (afeStart) begin
            aWait <= lag;
            aPh <= afePhase;
            lastSetup <= afeSetup;
            afeCount <= afeCount + 16'h1;
        end else if (aWait == 4'h1) begin
            afeDone <= 1'b1;
            afeResult <= {6'h00, aPh, lastSetup};
        end
        if (calcStart) begin
            cWait <= lag;
            run <= run + 8'h01;
            calcCount <= calcCount + 16'h1;
        end else if (cWait == 4'h1) begin
            calcDone <= 1'b1;
            calcSensor <= {16'h0000, run};
            calcTemp <= 24'h000100 + 24'h3 * run;
        end else if (idle) begin
            run <= 8'h00;
        end
        if (!reset_n) begin
            {aWait, cWait, run, afeCount, calcCount} <= 48'h0;
            {afeResult, calcSensor, calcTemp} <= 72'h0;
        end
    end
endmodule

// [measure_command_decoder_test.sv]
// self-checking bench for the measure command decoder
`timescale 1ns/1ps
module measure_command_decoder_test;
    reg         sys_clk = 1'b0;
    reg         reset_n = 1'b0;
    reg         cmdValid = 1'b0;
    reg  [7:0]  cmdByte = 8'h00;
    reg  [15:0] cmdData = 16'h0000;
    reg  [3:0]  lag = 4'h1;
    wire        cmdReady, afeStart, afeDone, calcStart, calcDone, calcSat;
    wire        haltPeriodic, sleepMode, respValid, dataValid;
    wire [1:0]  afePhase;
    wire [15:0] afeSetup, lastSetup, afeCount, calcCount;
    wire [7:0]  statusByte;
    wire [23:0] afeResult, calcSensor, calcTemp, outSensor, outTemp;
    reg  [15:0] d, s, a, c;
    integer     i, n, sm, errTotal = 0, checksDone = 0;
    always #20 sys_clk = ~sys_clk;
    mcd_decoder uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .cmdValid(cmdValid), .cmdByte(cmdByte), .cmdData(cmdData),
        .cmdReady(cmdReady), .sensorSetupPrimary(16'h1234),
        .sensorSetupAlternate(16'h5a17), .modeStatus(2'b01),
        .memError(1'b0), .afeStart(afeStart), .afePhase(afePhase),
        .afeSetup(afeSetup), .afeDone(afeDone), .afeResult(afeResult),
        .calcStart(calcStart), .calcDone(calcDone),
        .calcSensor(calcSensor), .calcTemp(calcTemp), .calcSat(calcSat),
        .haltPeriodic(haltPeriodic), .sleepMode(sleepMode),
        .statusByte(statusByte), .outSensor(outSensor), .outTemp(outTemp),
        .respValid(respValid), .dataValid(dataValid));
    mcd_afe_model model (.sys_clk(sys_clk), .reset_n(reset_n), .lag(lag),
        .idle(cmdReady), .afeStart(afeStart), .afePhase(afePhase),
        .afeSetup(afeSetup), .afeDone(afeDone), .afeResult(afeResult),
        .calcStart(calcStart), .calcDone(calcDone), .calcSat(calcSat),
        .calcSensor(calcSensor), .calcTemp(calcTemp),
        .lastSetup(lastSetup), .afeCount(afeCount), .calcCount(calcCount));
    task chk(input [23:0] got, input [23:0] exp);
        begin
            checksDone = checksDone + 1;
            if (got !== exp) begin
                errTotal = errTotal + 1;
                $display("Error %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task send(input [7:0] cb, input [15:0] cd);
        begin
            @(posedge sys_clk);
            cmdValid <= 1'b1;
            cmdByte <= cb;
            cmdData <= cd;
            @(posedge sys_clk);
            while (cmdReady !== 1'b1) @(posedge sys_clk);
            cmdValid <= 1'b0;
        end
    endtask
    task run(input [7:0] cb, input [15:0] cd);
        begin
            send(cb, cd);
            @(posedge sys_clk);
            chk(statusByte[5], 1'b1);
            while (respValid !== 1'b1) @(posedge sys_clk);
        end
    endtask
    task completeRun;
        begin
            if (errTotal == 0 && checksDone > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        errTotal = errTotal + 1;
        completeRun;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk(statusByte, 24'h48);
        for (i = 0; i < 8; i = i + 1) begin
            d = i[0] ? 16'hf5a3 : 16'h0000;
            s = i[0] ? d : (i[2] ? 16'h0000 : 16'h1234);
            if (i[2]) s = s & 16'h0fff;
            run({5'h14, i[2:0]}, d);
            chk(lastSetup, s);
            chk(outSensor, i[1] ? 24'h010000 : {6'h0, i[2], 1'b1, s});
            chk(outTemp, 24'h0);
        end
        send(8'hb1, 16'h0);
        @(posedge sys_clk);
        chk(statusByte[1], 1'b1);
        run(8'ha0, 16'h0);
        chk(outSensor, 24'h015a17);
        send(8'hf5, 16'h0);
        @(posedge sys_clk);
        chk(respValid, 1'b1);
        chk(outSensor, 24'h015a17);
        chk(dataValid, 1'b1);
        send(8'hb0, 16'h0);
        @(posedge sys_clk);
        chk(statusByte[1], 1'b0);
        send(8'hbf, 16'h0);
        @(posedge sys_clk);
        chk(sleepMode, 1'b1);
        chk(haltPeriodic, 1'b1);
        send(8'haa, 16'h0);
        @(posedge sys_clk);
        cmdValid <= 1'b1;
        cmdByte <= 8'hb1;
        repeat (4) @(posedge sys_clk);
        cmdValid <= 1'b0;
        chk(statusByte[5], 1'b1);
        chk(statusByte[1], 1'b0);
        while (respValid !== 1'b1) @(posedge sys_clk);
        chk(outSensor, 24'h000001);
        chk(outTemp, 24'h000103);
        lag <= 4'h3;
        for (i = 0; i < 3; i = i + 1) begin
            n = 4 << i;
            sm = n * (n + 1) / 2;
            a = afeCount;
            c = calcCount;
            run(8'had + i[7:0], 16'h0);
            chk(outSensor, sm / n);
            chk(outTemp, (256 * n + 3 * sm) / n);
            chk(afeCount - a, 4 * n);
            chk(calcCount - c, n);
            chk(statusByte[0], 1'b1);
            chk(sleepMode, 1'b0);
        end
        completeRun;
    end
endmodule
